// [acccr_top.sv]
/*
 * channel 2 configuration and calibration registers plus the channel 1
 * lower gain word, on an ahb-lite slave port.
 * assumes: single word transfers, one slave on the bus, hready looped
 * back from hreadyout; downstream converter takes the 24-bit values.
 */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module acccr_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [1:0] chan2_input_select,
   output logic chan2_connect_pins,
   output logic chan2_short_inputs,
   output logic chan2_test_pos,
   output logic chan2_test_neg,
   output logic [23:0] chan2_offset,
   output logic [23:0] chan2_gain,
   output logic [7:0] chan1_gain_low_bits,
   output logic cal_update
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   acccr_pkg::acccr_regs_t st_r;
   acccr_pkg::acccr_regs_t st_nxt;
   acccr_cal_if cal ();

   logic addr_take;
   logic [7:0] addr_idx;
   logic [15:0] wr_word;
   logic [15:0] rsv_seen;
   logic clr_rsv;

   // -------------------------------------------------------------------
   // read view of one register
   // -------------------------------------------------------------------
   function automatic logic [31:0] rd_word(
      input logic [7:0] idx,
      input acccr_pkg::acccr_regs_t s,
      input logic [3:0] route
   );
      logic [31:0] w;
      w = 32'h00000000;
      case (idx)
         acccr_pkg::IDX_CH1_GAIN_LO: begin
            w[15:0] = s.ch1_gain_lo & acccr_pkg::LO_WMASK;
         end
         acccr_pkg::IDX_CHAN2_CONFIG: begin
            w[15:0] = s.cfg & acccr_pkg::CFG_WMASK;
         end
         acccr_pkg::IDX_CH2_OFS_HI: begin
            w[15:0] = s.ofs_hi;
         end
         acccr_pkg::IDX_CH2_OFS_LO: begin
            w[15:0] = s.ofs_lo & acccr_pkg::LO_WMASK;
         end
         acccr_pkg::IDX_CH2_GAIN_HI: begin
            w[15:0] = s.gain_hi;
         end
         acccr_pkg::IDX_CH2_GAIN_LO: begin
            w[15:0] = s.gain_lo & acccr_pkg::LO_WMASK;
         end
         acccr_pkg::IDX_STATUS: begin
            w[acccr_pkg::STS_RSV_ERR_BIT] = s.rsv_err;
            w[acccr_pkg::STS_ROUTE_LSB +: 4] = route;
         end
         default: begin
            w = 32'h00000000;   // unmapped reads return zero
         end
      endcase
      return w;
   endfunction : rd_word

   // -------------------------------------------------------------------
   // address phase decode
   // -------------------------------------------------------------------
   // a transfer is taken when selected, active and the bus is ready
   assign addr_take = hsel && hready &&
                      (htrans == acccr_pkg::HTRANS_NONSEQ ||
                       htrans == acccr_pkg::HTRANS_SEQ);
   assign addr_idx = haddr[acccr_pkg::IDX_LSB +: 8];

   // data phase write word, low half only
   assign wr_word = hwdata[15:0];

   // reserved bits that a config write tried to set
   assign rsv_seen = wr_word & acccr_pkg::CFG_RSV_MASK;

   // status write of one to the error bit clears it
   assign clr_rsv = st_r.wr_pend && (st_r.wr_idx == acccr_pkg::IDX_STATUS)
                    && hwdata[acccr_pkg::STS_RSV_ERR_BIT];

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   // write data lands one cycle after its address phase; the read view
   // is taken from the updated copy so a read right after a write to
   // the same register already sees the new value
   always_comb begin
      st_nxt = st_r;
      st_nxt.cal_upd = 1'b0;
      if (st_r.wr_pend) begin
         case (st_r.wr_idx)
            acccr_pkg::IDX_CH1_GAIN_LO: begin
               st_nxt.ch1_gain_lo = wr_word & acccr_pkg::LO_WMASK;
               st_nxt.cal_upd = 1'b1;
            end
            acccr_pkg::IDX_CHAN2_CONFIG: begin
               // reserved writable bits are kept as written
               st_nxt.cfg = wr_word & acccr_pkg::CFG_WMASK;
            end
            acccr_pkg::IDX_CH2_OFS_HI: begin
               st_nxt.ofs_hi = wr_word;
               st_nxt.cal_upd = 1'b1;
            end
            acccr_pkg::IDX_CH2_OFS_LO: begin
               st_nxt.ofs_lo = wr_word & acccr_pkg::LO_WMASK;
               st_nxt.cal_upd = 1'b1;
            end
            acccr_pkg::IDX_CH2_GAIN_HI: begin
               st_nxt.gain_hi = wr_word;
               st_nxt.cal_upd = 1'b1;
            end
            acccr_pkg::IDX_CH2_GAIN_LO: begin
               st_nxt.gain_lo = wr_word & acccr_pkg::LO_WMASK;
               st_nxt.cal_upd = 1'b1;
            end
            default: begin
               st_nxt.cfg = st_r.cfg;   // unmapped writes are dropped
            end
         endcase
      end

      // sticky flag for nonzero reserved config writes; set beats clear
      if (clr_rsv) begin
         st_nxt.rsv_err = 1'b0;
      end
      if (st_r.wr_pend && st_r.wr_idx == acccr_pkg::IDX_CHAN2_CONFIG &&
          rsv_seen != 16'h0000) begin
         st_nxt.rsv_err = 1'b1;
      end

      // capture the address phase for the coming data phase
      st_nxt.wr_pend = addr_take && hwrite;
      st_nxt.wr_idx = addr_take ? addr_idx : st_r.wr_idx;

      // read data is ready at the start of the data phase
      if (addr_take && !hwrite) begin
         st_nxt.rdata = rd_word(addr_idx, st_nxt, cal.route);
      end else begin
         st_nxt.rdata = 32'h00000000;
      end
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '{cfg: acccr_pkg::RST_CFG,
                   ofs_hi: acccr_pkg::RST_OFS_HI,
                   ofs_lo: acccr_pkg::RST_OFS_LO,
                   gain_hi: acccr_pkg::RST_GAIN_HI,
                   gain_lo: acccr_pkg::RST_GAIN_LO,
                   ch1_gain_lo: acccr_pkg::RST_CH1_GAIN_LO,
                   rsv_err: 1'b0,
                   wr_pend: 1'b0,
                   wr_idx: 8'h00,
                   rdata: 32'h00000000,
                   cal_upd: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------
   // words handed to the helper modules
   // -------------------------------------------------------------------
   assign cal.sel = st_r.cfg[acccr_pkg::SEL_LSB +: 2];
   assign cal.ofs_hi = st_r.ofs_hi;
   assign cal.ofs_lo = st_r.ofs_lo;
   assign cal.gain_hi = st_r.gain_hi;
   assign cal.gain_lo = st_r.gain_lo;
   assign cal.ch1_gain_lo = st_r.ch1_gain_lo;

   // joins calibration words into 24-bit values
   acccr_join i_acccr_join (
      .hclk(hclk),
      .hresetn(hresetn),
      .cal(cal.joiner)
   );

   // drives the input switch controls
   acccr_route i_acccr_route (
      .hclk(hclk),
      .hresetn(hresetn),
      .cal(cal.router)
   );

   // -------------------------------------------------------------------
   // bus answer
   // -------------------------------------------------------------------
   // zero wait states and always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_r.rdata;

   // -------------------------------------------------------------------
   // datapath outputs
   // -------------------------------------------------------------------
   // offset is two's complement, gain unsigned with 800000h as unity
   assign chan2_input_select = st_r.cfg[acccr_pkg::SEL_LSB +: 2];
   assign chan2_connect_pins = cal.route[0];
   assign chan2_short_inputs = cal.route[1];
   assign chan2_test_pos = cal.route[2];
   assign chan2_test_neg = cal.route[3];
   assign chan2_offset = cal.offset;
   assign chan2_gain = cal.gain;
   assign chan1_gain_low_bits = cal.ch1_low;
   assign cal_update = st_r.cal_upd;   // joined values valid next cycle

endmodule : acccr_top

// [acccr_pkg.sv]
/*
 * constants, field layouts, reset values and state types for the channel
 * calibration and configuration register bank.
 * assumes: a 32-bit ahb-lite slave port, one register per aligned word.
 */
package acccr_pkg;

   // -------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -------------------------------------------------------------------
   localparam logic [7:0] IDX_CH1_GAIN_LO = 8'h12;
   localparam logic [7:0] IDX_CHAN2_CONFIG = 8'h13;
   localparam logic [7:0] IDX_CH2_OFS_HI = 8'h14;
   localparam logic [7:0] IDX_CH2_OFS_LO = 8'h15;
   localparam logic [7:0] IDX_CH2_GAIN_HI = 8'h16;
   localparam logic [7:0] IDX_CH2_GAIN_LO = 8'h17;
   localparam logic [7:0] IDX_STATUS = 8'h20;
   localparam int unsigned IDX_LSB = 2;

   // -------------------------------------------------------------------
   // reset values and field layout
   // -------------------------------------------------------------------
   localparam logic [15:0] RST_CFG = 16'h0000;
   localparam logic [15:0] RST_OFS_HI = 16'h0000;
   localparam logic [15:0] RST_OFS_LO = 16'h0000;
   localparam logic [15:0] RST_GAIN_HI = 16'h8000;
   localparam logic [15:0] RST_GAIN_LO = 16'h0000;
   localparam logic [15:0] RST_CH1_GAIN_LO = 16'h0000;
   localparam logic [15:0] CFG_WMASK = 16'hffc7;   // bits 5:3 read only
   localparam logic [15:0] CFG_RSV_MASK = 16'hffc4; // writable reserved
   localparam logic [15:0] LO_WMASK = 16'hff00;    // bits 7:0 read zero
   localparam int unsigned SEL_LSB = 0;
   localparam int unsigned LO_FIELD_LSB = 8;
   localparam int unsigned STS_RSV_ERR_BIT = 0;
   localparam int unsigned STS_ROUTE_LSB = 1;
   localparam logic [23:0] GAIN_UNITY = 24'h800000;

   // -------------------------------------------------------------------
   // bus encodings
   // -------------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   // input selection codes
   typedef enum logic [1:0] {
      ACCCR_SEL_PINS = 2'h0,
      ACCCR_SEL_SHORT = 2'h1,
      ACCCR_SEL_TEST_POS = 2'h2,
      ACCCR_SEL_TEST_NEG = 2'h3
   } acccr_sel_t;

   // register bank state
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] ofs_hi;
      logic [15:0] ofs_lo;
      logic [15:0] gain_hi;
      logic [15:0] gain_lo;
      logic [15:0] ch1_gain_lo;
      logic rsv_err;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic cal_upd;
   } acccr_regs_t;

   typedef struct packed {
      logic [23:0] offset;
      logic [23:0] gain;
      logic [7:0] ch1_low;
   } acccr_join_t;

   typedef struct packed {
      logic [3:0] route;
   } acccr_route_t;

endpackage : acccr_pkg

// [acccr_cal_if.sv]
/*
 * carrier between the register bank and its two helper modules.
 * assumes: all three sides run on the same hclk.
 */
`timescale 1ns/1ps
interface acccr_cal_if;
   logic [1:0] sel;
   logic [15:0] ofs_hi;
   logic [15:0] ofs_lo;
   logic [15:0] gain_hi;
   logic [15:0] gain_lo;
   logic [15:0] ch1_gain_lo;
   logic [23:0] offset;
   logic [23:0] gain;
   logic [7:0] ch1_low;
   logic [3:0] route;

   modport regs (output sel, ofs_hi, ofs_lo, gain_hi, gain_lo, ch1_gain_lo,
                 input offset, gain, ch1_low, route);
   modport joiner (input ofs_hi, ofs_lo, gain_hi, gain_lo, ch1_gain_lo,
                   output offset, gain, ch1_low);
   modport router (input sel, output route);
endinterface : acccr_cal_if

// [acccr_join.sv]
/*
 * joins upper and lower calibration words into 24-bit values.
 * assumes: word inputs come straight from the register bank flops.
 */
`timescale 1ns/1ps
module acccr_join (
   input wire logic hclk,
   input wire logic hresetn,
   acccr_cal_if.joiner cal
);
   acccr_pkg::acccr_join_t st_r;
   acccr_pkg::acccr_join_t st_nxt;

   // concatenate upper word with lower word bits 15:8
   always_comb begin
      st_nxt = st_r;
      st_nxt.offset = {cal.ofs_hi, cal.ofs_lo[15:8]};
      st_nxt.gain = {cal.gain_hi, cal.gain_lo[15:8]};
      st_nxt.ch1_low = cal.ch1_gain_lo[15:8];
   end

   // register the joined values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '{offset: 24'h000000, gain: acccr_pkg::GAIN_UNITY,
                   ch1_low: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cal.offset = st_r.offset;
   assign cal.gain = st_r.gain;
   assign cal.ch1_low = st_r.ch1_low;
endmodule : acccr_join

// [acccr_route.sv]
/*
 * decodes the channel 2 input selection into one-hot switch controls.
 * assumes: bit 0 pins, bit 1 short, bit 2 positive test, bit 3 negative.
 */
`timescale 1ns/1ps
module acccr_route (
   input wire logic hclk,
   input wire logic hresetn,
   acccr_cal_if.router cal
);
   acccr_pkg::acccr_route_t st_r;
   acccr_pkg::acccr_route_t st_nxt;

   // one switch group closed per selection code
   always_comb begin
      st_nxt = st_r;
      case (acccr_pkg::acccr_sel_t'(cal.sel))
         acccr_pkg::ACCCR_SEL_PINS: st_nxt.route = 4'h1;
         acccr_pkg::ACCCR_SEL_SHORT: st_nxt.route = 4'h2;
         acccr_pkg::ACCCR_SEL_TEST_POS: st_nxt.route = 4'h4;
         acccr_pkg::ACCCR_SEL_TEST_NEG: st_nxt.route = 4'h8;
         default: st_nxt.route = 4'h1;
      endcase
   end

   // register the switch controls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '{route: 4'h1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cal.route = st_r.route;
endmodule : acccr_route

// [acccr_monitor.sv]
/*
 * concurrent checks on the ports of the calibration register bank.
 * assumes: bound onto acccr_top, hready driven from hreadyout.
 */
`timescale 1ns/1ps
module acccr_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] chan2_input_select,
   input wire logic chan2_connect_pins,
   input wire logic chan2_short_inputs,
   input wire logic chan2_test_pos,
   input wire logic chan2_test_neg,
   input wire logic [23:0] chan2_offset,
   input wire logic [23:0] chan2_gain,
   input wire logic [7:0] chan1_gain_low_bits,
   input wire logic cal_update
);
   logic rd_ph_r;
   logic wr_cal_r;
   logic [7:0] rd_idx_r;
   logic [3:0] route;

   // -------------------------------------------------------------------
   // read data phase tracking
   // -------------------------------------------------------------------
   assign route = {chan2_test_neg, chan2_test_pos, chan2_short_inputs,
                   chan2_connect_pins};
   // remember which index the current data phase reads
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ph_r <= 1'b0;
         wr_cal_r <= 1'b0;
         rd_idx_r <= 8'h00;
      end else begin
         rd_ph_r <= hsel && hready && htrans[1] && !hwrite;
         // write data phase to a calibration word
         wr_cal_r <= hsel && hready && htrans[1] && hwrite &&
            haddr[9:2] inside {8'h12, 8'h14, 8'h15, 8'h16, 8'h17};
         rd_idx_r <= haddr[9:2];
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
   AST_RD_IDLE: assert property (!rd_ph_r |-> hrdata == 32'h0)
      else $error("read data outside phase");
   AST_RD_UPPER: assert property (rd_ph_r |-> hrdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
   AST_LO_RSV: assert property (rd_ph_r && rd_idx_r inside
      {8'h12, 8'h15, 8'h17} |-> hrdata[7:0] == 8'h00)
      else $error("lower word reserved bits not zero");
   AST_CFG_RSV: assert property (rd_ph_r && rd_idx_r == 8'h13 |->
      hrdata[5:3] == 3'h0) else $error("config bits 5:3 not zero");
   AST_OFS_HI: assert property (rd_ph_r && rd_idx_r == 8'h14 &&
      !cal_update |-> hrdata[15:0] == chan2_offset[23:8])
      else $error("offset upper word differs from joined offset");
   AST_OFS_LO: assert property (rd_ph_r && rd_idx_r == 8'h15 &&
      !cal_update |-> hrdata[15:8] == chan2_offset[7:0])
      else $error("offset lower word differs from joined offset");
   AST_GAIN_HI: assert property (rd_ph_r && rd_idx_r == 8'h16 &&
      !cal_update |-> hrdata[15:0] == chan2_gain[23:8])
      else $error("gain upper word differs from joined gain");
   AST_GAIN_LO: assert property (rd_ph_r && rd_idx_r == 8'h17 &&
      !cal_update |-> hrdata[15:8] == chan2_gain[7:0])
      else $error("gain lower word differs from joined gain");
   AST_CH1_LO: assert property (rd_ph_r && rd_idx_r == 8'h12 &&
      !cal_update |-> hrdata[15:8] == chan1_gain_low_bits)
      else $error("channel 1 low gain bits differ");
   AST_CAL_CHG: assert property ($changed({chan2_offset,
      chan2_gain, chan1_gain_low_bits}) |-> $past(cal_update))
      else $error("joined value moved without a calibration write");
   AST_CAL_PULSE: assert property (cal_update == $past(wr_cal_r))
      else $error("calibration pulse does not follow a word write");
   AST_ROUTE_ONE: assert property ($onehot(route))
      else $error("routing controls not one-hot");
   AST_ROUTE_SEL: assert property ($stable(chan2_input_select) |->
      route == 4'h1 << chan2_input_select)
      else $error("routing does not follow the select field");
endmodule : acccr_monitor

bind acccr_top acccr_monitor i_acccr_monitor (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp),
   .chan2_input_select(chan2_input_select),
   .chan2_connect_pins(chan2_connect_pins),
   .chan2_short_inputs(chan2_short_inputs),
   .chan2_test_pos(chan2_test_pos), .chan2_test_neg(chan2_test_neg),
   .chan2_offset(chan2_offset), .chan2_gain(chan2_gain),
   .chan1_gain_low_bits(chan1_gain_low_bits), .cal_update(cal_update));

// [acccr_top_test.sv]
/*
 * self-checking bench for the calibration register bank with a model.
 * assumes: one ahb-lite master here, hready looped from hreadyout.
 */
`timescale 1ns/1ps
module acccr_top_test;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cal_update;
   logic [31:0] haddr, hwdata, hrdata, rd, wd;
   logic [1:0] htrans, sel;
   logic [2:0] hsize;
   logic [3:0] route;
   logic [23:0] ofs, gain;
   logic [7:0] ch1, idx;
   logic [15:0] mdl [0:255];
   logic mdl_err;
   logic [7:0] pick [9] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
                             8'h11, 8'h18, 8'h3e};
   int fails = 0;
   int checks = 0;
   integer seed = 12;

   acccr_top i_acccr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .chan2_input_select(sel),
      .chan2_connect_pins(route[0]), .chan2_short_inputs(route[1]),
      .chan2_test_pos(route[2]), .chan2_test_neg(route[3]),
      .chan2_offset(ofs), .chan2_gain(gain), .chan1_gain_low_bits(ch1),
      .cal_update(cal_update));
   assign hready = hreadyout;

   // -------------------------------------------------------------------
   // clock, model and bus tasks
   // -------------------------------------------------------------------
   // free-running 10 MHz clock
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected read data: expected %h, seen %h", exp, got);
      end
   endtask : chk_rd

   task automatic chk_out(input logic [61:0] exp, input logic [61:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected outputs: expected %h, seen %h", exp, got);
      end
   endtask : chk_out

   task automatic mdl_wr(input logic [7:0] i, input logic [15:0] d);
      case (i)
         8'h13: begin
            mdl[i] = d & 16'hffc7;
            if ((d & 16'hffc4) != 16'h0) mdl_err = 1'b1;
         end
         8'h12, 8'h15, 8'h17: mdl[i] = d & 16'hff00;
         8'h14, 8'h16: mdl[i] = d;
         8'h20: if (d[0]) mdl_err = 1'b0;
         default: ;
      endcase
   endtask : mdl_wr

   function automatic logic [31:0] mdl_rd(input logic [7:0] i);
      if (i == 8'h20) return {27'h0, 4'h1 << mdl[8'h13][1:0], mdl_err};
      if (i >= 8'h12 && i <= 8'h17) return {16'h0, mdl[i]};
      return 32'h0;
   endfunction : mdl_rd

   // one single transfer; read data taken at the end of the data phase
   task automatic xfer(input logic w, input logic [7:0] i,
                       input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      if (w) mdl_wr(i, wd[15:0]);
   endtask : xfer

   task automatic rd_chk(input logic [7:0] i);
      xfer(1'b0, i, $random(seed));
      chk_rd(mdl_rd(i), rd);
   endtask : rd_chk

   // read every mapped word, then compare the datapath outputs
   task automatic check_all;
      logic [7:0] regs [7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
                               8'h20};
      foreach (regs[i]) rd_chk(regs[i]);
      chk_out({mdl[8'h13][1:0], 4'h1 << mdl[8'h13][1:0], mdl[8'h14],
         mdl[8'h15][15:8], mdl[8'h16], mdl[8'h17][15:8], mdl[8'h12][15:8]},
         {sel, route, ofs, gain, ch1});
   endtask : check_all

   task automatic do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (mdl[i]) mdl[i] = 16'h0000;
      mdl[8'h16] = 16'h8000;
      mdl_err = 1'b0;
   endtask : do_reset

   task automatic tally_and_finish;
      $display("checks %0d, fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   // -------------------------------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      do_reset();
      check_all();
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, 8'h13, c);
         check_all();
      end
      xfer(1'b1, 8'h13, 32'hffff_ffff);
      check_all();
      xfer(1'b1, 8'h20, 32'h0000_0001);
      rd_chk(8'h20);
      for (int n = 0; n < 60; n++) begin
         idx = pick[$unsigned($random(seed)) % 9];
         wd = $random(seed);
         // host keeps config reserved bits 15:6 and 2 at zero
         if (idx == 8'h13) wd = wd & 32'h0000_003b;
         xfer(1'b1, idx, wd);
         rd_chk(idx);
         if (n % 6 == 5) check_all();
      end
      do_reset();
      check_all();
      tally_and_finish();
   end

   // cuts a hang short well past the expected run length
   initial begin
      #3000000;
      fails++;
      tally_and_finish();
   end
endmodule : acccr_top_test
